// ==== logic/wdt_sleep_ctrl.sv ====
// Overview of operation
// - interrupt entry pushes only the return program counter; nothing else is saved.
// - watchdog counts its own free oscillator, so it runs while main clock stops.
// - watchdog expiry during normal running issues a watchdog-kind device reset.
// - watchdog expiry during power-down wakes the device to continue execution.
// - any watchdog expiry clears the time-out flag, status bit 4.
// - cleared watchdog enable fuse disables the watchdog permanently.
// - postscaler is the timer0 prescaler; option_control bit 3 assigns, bits 2:0 select.
// - watchdog-clear or power-down instruction clears watchdog and assigned postscaler.
// - watchdog-clear leaves the prescaler assignment bit unchanged.
// - power-down clears powerdown flag, sets timeout flag, clears watchdog, stops oscillator.
// - pins hold their drive state throughout power-down.
// - wake on master clear, enabled watchdog expiry, or enabled wake interrupts.
// - master-clear wake is a full reset; other wakes continue execution.
// - peripheral wake only from async timer one, capture, or special trigger.
// - internally clocked peripherals raise no wake during power-down.
// - power-down instruction prefetches the next program address.
// - a source wakes only if its own enable is set, regardless of global enable.
// - interrupt wake with global enable clear continues without vectoring.
// - interrupt wake with global enable set runs next instruction, then vectors.
// - powerdown flag set at power-up, cleared by every power-down instruction that is not made a no-operation.
// - watchdog division ratios run 1:1 to 1:128 in powers of two.
// - pending enabled interrupt with global enable clear makes power-down a no-operation.
// - interrupt arriving during or after power-down instruction wakes right after it.
//
// Design decision made here: the APB slave port.
module wdt_sleep_ctrl #(
   parameter int WDT_BASE = wdt_sleep_pkg::WDT_BASE_CYCLES
)(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // pins and fuse
   input wire logic WDT_OSC,
   input wire logic MASTER_CLEAR_PIN_N,
   input wire logic WATCHDOG_ENABLE_FUSE,
   // core events, same clock
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic SLEEP_INSTR,
   input wire logic IRQ_ENTRY,
   input wire logic IRQ_PENDING,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic TIMER0_TICK,
   input wire logic TIMER0_WRITE,
   // wake requests from interrupt sources
   input wire logic [5:0] WAKE_REQ,
   // outputs to core and system
   output logic WATCHDOG_RESET,
   output logic MASTER_RESET,
   output logic WAKE_RESUME,
   output logic WAKE_VECTOR,
   output logic PREFETCH_NEXT,
   output logic STACK_PUSH_PC,
   output logic OSC_DRIVER_EN,
   output logic IO_HOLD,
   output logic TIMER0_INC
);
   // synchronisers
   logic [2:0] osc_sync_r;
   logic [2:0] master_clear_pin_sync_r;
   logic osc_lvl_r;
   logic osc_prev_r;
   logic master_clear_pin_n_lvl_r;
   logic master_clear_pin_prev_r;
   // registers and state
   logic [7:0] option_r;
   logic [5:0] wake_en_r;
   logic timeout_flag_r;
   logic powerdown_flag_r;
   logic fuse_r;
   wdt_sleep_pkg::power_state_t state_r;
   logic [15:0] base_cnt_r;
   logic [7:0] prescale_cnt_r;
   logic [7:0] tap_mask;
   logic osc_edge;
   logic master_clear_pin_fall;
   logic base_expire;
   logic prescaler_assign_bit;
   logic [2:0] ps_sel;
   logic wdt_clear;
   logic sleep_taken;
   logic wdt_timeout;
   logic irq_wake;
   logic [5:0] wake_allowed;
   logic prescale_tap;
   logic prescale_src;
   logic bus_access;
   logic bus_write;

   assign prescaler_assign_bit = option_r[wdt_sleep_pkg::PRESCALER_ASSIGN_BIT];
   assign ps_sel = option_r[wdt_sleep_pkg::PRESCALE_SELECT_MSB:wdt_sleep_pkg::PRESCALE_SELECT_LSB];
   // three-stage pin synchronisers; a change counts once stages two and three agree
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         osc_sync_r <= 3'h0;
         master_clear_pin_sync_r <= 3'h7;
         osc_lvl_r <= 1'b0;
         osc_prev_r <= 1'b0;
         master_clear_pin_n_lvl_r <= 1'b1;
         master_clear_pin_prev_r <= 1'b1;
      end
      else
      begin
         osc_sync_r <= {osc_sync_r[1:0], WDT_OSC};
         master_clear_pin_sync_r <= {master_clear_pin_sync_r[1:0], MASTER_CLEAR_PIN_N};
         if (osc_sync_r[1] == osc_sync_r[2])
            osc_lvl_r <= osc_sync_r[2];
         if (master_clear_pin_sync_r[1] == master_clear_pin_sync_r[2])
            master_clear_pin_n_lvl_r <= master_clear_pin_sync_r[2];
         osc_prev_r <= osc_lvl_r;
         master_clear_pin_prev_r <= master_clear_pin_n_lvl_r;
      end
   end

   assign osc_edge = osc_lvl_r & ~osc_prev_r;
   assign master_clear_pin_fall = master_clear_pin_prev_r & ~master_clear_pin_n_lvl_r;
   // fuse is static; caught while reset is held so software cannot touch it
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
         fuse_r <= WATCHDOG_ENABLE_FUSE;
   end

   // pending interrupt with global enable clear turns power-down into a no-operation
   assign sleep_taken = SLEEP_INSTR & (state_r == wdt_sleep_pkg::RUN_ST)
                        & ~(IRQ_PENDING & ~GLOBAL_IRQ_ENABLE);
   assign wdt_clear = WATCHDOG_CLEAR_INSTR | sleep_taken;

   // base count runs on watchdog oscillator edges only
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET || wdt_clear || !fuse_r)
         base_cnt_r <= 16'h0000;
      else if (osc_edge)
      begin
         if (base_cnt_r == 16'(WDT_BASE - 1))
            base_cnt_r <= 16'h0000;
         else
            base_cnt_r <= base_cnt_r + 16'h0001;
      end
   end

   assign base_expire = fuse_r & osc_edge & (base_cnt_r == 16'(WDT_BASE - 1));
   // shared counter fed by watchdog base or timer0 clock per assignment
   assign prescale_src = prescaler_assign_bit ? base_expire : TIMER0_TICK;
   // watchdog ratio 2^ps, 1:1 to 1:128; timer0 gets 2^(ps+1)
   // a tap fires when every counted bit below it is one, so the one prescale count serves every ratio
   assign tap_mask = prescaler_assign_bit ? ((8'h01 << ps_sel) - 8'h01) : ((8'h02 << ps_sel) - 8'h01);
   assign prescale_tap = prescale_src & ((prescale_cnt_r & tap_mask) == tap_mask);
   assign wdt_timeout = prescaler_assign_bit ? prescale_tap : base_expire;

   // postscaler clear only if assigned to watchdog
   // assignment bit is left alone here
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
         prescale_cnt_r <= 8'h00;
      else if ((prescaler_assign_bit && wdt_clear) || (!prescaler_assign_bit && TIMER0_WRITE))
         prescale_cnt_r <= 8'h00;
      else if (prescale_src)
         prescale_cnt_r <= prescale_cnt_r + 8'h01;
   end

   // timer0 increment pulse when prescaler belongs to timer0
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
         TIMER0_INC <= 1'b0;
      else
         TIMER0_INC <= ~prescaler_assign_bit & prescale_tap;
   end

   // only async timer one, capture and special trigger peripherals
   // internally clocked sources are masked in power-down
   // each source gated by its own enable, not global enable
   always_comb
   begin
      wake_allowed = WAKE_REQ & wake_en_r;
      if (state_r == wdt_sleep_pkg::SLEEP_ST)
         wake_allowed[wdt_sleep_pkg::WAKE_CLOCKED_PERIPH_BIT] = 1'b0;
   end

   // an interrupt during or after power-down wakes at once
   assign irq_wake = (|wake_allowed) | IRQ_PENDING;

   // power state machine
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
         state_r <= wdt_sleep_pkg::RUN_ST;
      else
      begin
         case (state_r)
            wdt_sleep_pkg::RUN_ST:
               if (sleep_taken && !master_clear_pin_fall)
                  state_r <= wdt_sleep_pkg::SLEEP_ST;
            wdt_sleep_pkg::SLEEP_ST:
               // master clear, watchdog or enabled interrupt ends sleep
               if (master_clear_pin_fall || wdt_timeout || irq_wake)
                  state_r <= wdt_sleep_pkg::RUN_ST;
            default:
               state_r <= wdt_sleep_pkg::RUN_ST;
         endcase
      end
   end

   // status flags; expiry wins over the power-down set in the same cycle
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         timeout_flag_r <= 1'b1;
         powerdown_flag_r <= 1'b1;
      end
      else if (master_clear_pin_fall)
      begin
         if (state_r == wdt_sleep_pkg::SLEEP_ST)
            timeout_flag_r <= 1'b1;
      end
      else if (wdt_timeout)
      begin
         timeout_flag_r <= 1'b0;
         if (state_r == wdt_sleep_pkg::RUN_ST && !sleep_taken)
            powerdown_flag_r <= 1'b1;
         else
            powerdown_flag_r <= 1'b0;
      end
      else if (sleep_taken)
      begin
         // power-down flag cleared, timeout flag set
         timeout_flag_r <= 1'b1;
         powerdown_flag_r <= 1'b0;
      end
      else if (WATCHDOG_CLEAR_INSTR)
      begin
         timeout_flag_r <= 1'b1;
         powerdown_flag_r <= 1'b1;
      end
   end

   // resets and wake pulses to the core
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         WATCHDOG_RESET <= 1'b0;
         MASTER_RESET <= 1'b0;
         WAKE_RESUME <= 1'b0;
         WAKE_VECTOR <= 1'b0;
      end
      else
      begin
         // master clear is a full reset, in or out of sleep
         MASTER_RESET <= master_clear_pin_fall;
         // expiry while running resets the device
         WATCHDOG_RESET <= ~master_clear_pin_fall & wdt_timeout & (state_r == wdt_sleep_pkg::RUN_ST)
                           & ~sleep_taken;
         // expiry or interrupt in sleep resumes execution
         WAKE_RESUME <= ~master_clear_pin_fall & (state_r == wdt_sleep_pkg::SLEEP_ST)
                        & (wdt_timeout | irq_wake);
         // no vector with global enable clear
         // next instruction first, then vector at 0004h
         WAKE_VECTOR <= ~master_clear_pin_fall & ~wdt_timeout & (state_r == wdt_sleep_pkg::SLEEP_ST)
                        & irq_wake & GLOBAL_IRQ_ENABLE;
      end
   end

   // oscillator driver, pin hold, prefetch and stack push
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         OSC_DRIVER_EN <= 1'b1;
         IO_HOLD <= 1'b0;
         PREFETCH_NEXT <= 1'b0;
         STACK_PUSH_PC <= 1'b0;
      end
      else
      begin
         OSC_DRIVER_EN <= ~(sleep_taken & ~master_clear_pin_fall)
                          & ~((state_r == wdt_sleep_pkg::SLEEP_ST)
                              & ~(master_clear_pin_fall | wdt_timeout | irq_wake));
         IO_HOLD <= (sleep_taken & ~master_clear_pin_fall)
                    | ((state_r == wdt_sleep_pkg::SLEEP_ST)
                       & ~(master_clear_pin_fall | wdt_timeout | irq_wake));
         // prefetch of next address while power-down executes
         PREFETCH_NEXT <= SLEEP_INSTR;
         // only the return address is pushed
         STACK_PUSH_PC <= IRQ_ENTRY;
      end
   end

   // apb: one wait state, answer registered
   assign bus_access = PSEL & PENABLE & ~PREADY;
   assign bus_write = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= wdt_sleep_pkg::APB_ZERO;
      end
      else if (bus_access)
      begin
         PREADY <= 1'b1;
         PSLVERR <= 1'b0;
         PRDATA <= wdt_sleep_pkg::APB_ZERO;
         case (PADDR)
            wdt_sleep_pkg::ADDR_OPTION:
               if (!PWRITE)
                  PRDATA <= {24'h000000, option_r};
            wdt_sleep_pkg::ADDR_WAKE_EN:
               if (!PWRITE)
                  PRDATA <= {26'h0000000, wake_en_r};
            wdt_sleep_pkg::ADDR_STATUS:
               if (!PWRITE)
                  PRDATA <= {27'h0000000, timeout_flag_r, powerdown_flag_r, 2'b00,
                             state_r == wdt_sleep_pkg::SLEEP_ST};
               else
                  PSLVERR <= 1'b1; // flags are hardware-owned
            default:
               PSLVERR <= 1'b1;
         endcase
      end
      else
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // software-writable registers
   // no register here can turn the watchdog back on
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         option_r <= wdt_sleep_pkg::OPTION_RESET;
         wake_en_r <= wdt_sleep_pkg::WAKE_EN_RESET;
      end
      else if (bus_write)
      begin
         if (PADDR == wdt_sleep_pkg::ADDR_OPTION)
            option_r <= PWDATA[7:0];
         if (PADDR == wdt_sleep_pkg::ADDR_WAKE_EN)
            wake_en_r <= PWDATA[5:0];
      end
   end

endmodule // wdt_sleep_ctrl

// ==== logic/wdt_sleep_pkg.sv ====
package wdt_sleep_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [9:0] IDX_OPTION = 10'h081;
   localparam logic [9:0] IDX_STATUS = 10'h003;
   localparam logic [9:0] IDX_WAKE_EN = 10'h010;
   localparam logic [11:0] ADDR_OPTION = {IDX_OPTION, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [11:0] ADDR_WAKE_EN = {IDX_WAKE_EN, 2'b00};
   // option_control fields
   localparam int PRESCALER_ASSIGN_BIT = 3;
   localparam int PRESCALE_SELECT_MSB = 2;
   localparam int PRESCALE_SELECT_LSB = 0;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   // status fields
   localparam int TIMEOUT_FLAG_BIT = 4;
   localparam int POWERDOWN_FLAG_BIT = 3;
   localparam int SLEEPING_BIT = 0;
   // wake enable fields
   localparam int WAKE_INT_BIT = 0;
   localparam int WAKE_PORT_CHANGE_BIT = 1;
   localparam int WAKE_TIMER_ONE_BIT = 2;
   localparam int WAKE_CAPTURE_BIT = 3;
   localparam int WAKE_SPECIAL_TRIG_BIT = 4;
   localparam int WAKE_CLOCKED_PERIPH_BIT = 5;
   localparam int WAKE_SRC_COUNT = 6;
   localparam logic [5:0] WAKE_EN_RESET = 6'h00;
   // watchdog base period in watchdog-oscillator cycles
   localparam int WDT_BASE_CYCLES = 1024;
   localparam logic [31:0] APB_ZERO = 32'h00000000;
   typedef enum logic [1:0]
   {
      RUN_ST = 2'b00,
      SLEEP_ST = 2'b01
   } power_state_t;
endpackage

// ==== testbench/wdt_osc_model.sv ====
module wdt_osc_model #(
   parameter int HALF_NS = 515
)(
   // free watchdog oscillator
   output logic WDT_OSC
);
   timeunit 1ns;
   timeprecision 1ns;
   // own free clock
   // never stops, and its period is unrelated to the bus clock
   initial
   begin
      WDT_OSC = 1'b0;
      forever #(HALF_NS) WDT_OSC = ~WDT_OSC;
   end
endmodule // wdt_osc_model

// ==== testbench/wdt_sleep_ctrl_chk.sv ====
module wdt_sleep_ctrl_chk #(
   parameter int WDT_BASE = 4
)(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET,
   // inputs watched, plus the PREADY output
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic WATCHDOG_ENABLE_FUSE,
   input wire logic SLEEP_INSTR,
   input wire logic IRQ_PENDING,
   input wire logic GLOBAL_IRQ_ENABLE,
   // outputs watched
   input wire logic WATCHDOG_RESET,
   input wire logic MASTER_RESET,
   input wire logic WAKE_RESUME,
   input wire logic WAKE_VECTOR,
   input wire logic PREFETCH_NEXT,
   input wire logic OSC_DRIVER_EN,
   input wire logic IO_HOLD
);
   timeunit 1ns;
   timeprecision 1ns;
   logic fuse_r;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // fuse copy, taken only under reset as the design does
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         fuse_r <= WATCHDOG_ENABLE_FUSE;
      end
   end
   sleep_entry_a: assert property (
      SLEEP_INSTR && OSC_DRIVER_EN && !(IRQ_PENDING && !GLOBAL_IRQ_ENABLE)
      |=> !OSC_DRIVER_EN || WATCHDOG_RESET || MASTER_RESET)
      else $error("sleep did not stop the oscillator");
   pins_held_a: assert property ($fell(IO_HOLD) |-> WAKE_RESUME || MASTER_RESET)
      else $error("pins released without a wake");
   sleep_nop_a: assert property (
      SLEEP_INSTR && OSC_DRIVER_EN && IRQ_PENDING && !GLOBAL_IRQ_ENABLE |=> OSC_DRIVER_EN [*2])
      else $error("sleep entered with interrupt pending");
   prefetch_a: assert property (SLEEP_INSTR |=> PREFETCH_NEXT)
      else $error("no prefetch after sleep");
   vector_gie_a: assert property (WAKE_VECTOR |-> WAKE_RESUME && $past(GLOBAL_IRQ_ENABLE))
      else $error("vector without wake or global enable");
   no_vector_a: assert property (WAKE_RESUME && !$past(GLOBAL_IRQ_ENABLE) |-> !WAKE_VECTOR)
      else $error("vector with global enable clear");
   wake_exits_a: assert property (
      WAKE_RESUME |-> OSC_DRIVER_EN && !$past(OSC_DRIVER_EN))
      else $error("resume not from sleep");
   wdt_running_a: assert property (WATCHDOG_RESET |-> $past(OSC_DRIVER_EN) && !WAKE_RESUME)
      else $error("watchdog reset issued from sleep");
   master_clear_pin_first_a: assert property (MASTER_RESET |-> !WATCHDOG_RESET && !WAKE_RESUME)
      else $error("master clear not given priority");
   fuse_off_a: assert property (!fuse_r |-> !WATCHDOG_RESET)
      else $error("watchdog reset with fuse cleared");
   apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("register access not answered");
endmodule // wdt_sleep_ctrl_chk

bind wdt_sleep_ctrl wdt_sleep_ctrl_chk #(.WDT_BASE(WDT_BASE)) i_chk (
   .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .WATCHDOG_ENABLE_FUSE(WATCHDOG_ENABLE_FUSE), .SLEEP_INSTR(SLEEP_INSTR),
   .IRQ_PENDING(IRQ_PENDING), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
   .WATCHDOG_RESET(WATCHDOG_RESET), .MASTER_RESET(MASTER_RESET), .WAKE_RESUME(WAKE_RESUME),
   .WAKE_VECTOR(WAKE_VECTOR), .PREFETCH_NEXT(PREFETCH_NEXT), .OSC_DRIVER_EN(OSC_DRIVER_EN),
   .IO_HOLD(IO_HOLD));

// ==== testbench/wdt_sleep_ctrl_tb.sv ====
module wdt_sleep_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BASE = 4;
   localparam logic [11:0] OPT = wdt_sleep_pkg::ADDR_OPTION;
   localparam logic [11:0] ST = wdt_sleep_pkg::ADDR_STATUS;
   localparam logic [11:0] WEN = wdt_sleep_pkg::ADDR_WAKE_EN;
   logic sys_clk, reset, psel, penable, pwrite, master_clear_pin_n, fuse, clr_i, sleep_i, irq_i, t0_tick;
   logic irq_pending, global_irq_enable, t0_write, wdt_osc, pready, pslverr, err, wdt_rst, mst_rst, resume;
   logic vector, prefetch, push_pc, osc_en, io_hold, t0_inc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] wake_req;
   int n_fail, cmp_count, cyc, n_wdr, n_inc, n_mst, n_psh, osc_cnt, n, m;
   wdt_sleep_ctrl #(.WDT_BASE(BASE)) i_dut (
      .SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WDT_OSC(wdt_osc), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .WATCHDOG_ENABLE_FUSE(fuse),
      .WATCHDOG_CLEAR_INSTR(clr_i), .SLEEP_INSTR(sleep_i), .IRQ_ENTRY(irq_i),
      .IRQ_PENDING(irq_pending), .GLOBAL_IRQ_ENABLE(global_irq_enable), .TIMER0_TICK(t0_tick),
      .TIMER0_WRITE(t0_write), .WAKE_REQ(wake_req), .WATCHDOG_RESET(wdt_rst),
      .MASTER_RESET(mst_rst), .WAKE_RESUME(resume), .WAKE_VECTOR(vector),
      .PREFETCH_NEXT(prefetch), .STACK_PUSH_PC(push_pc), .OSC_DRIVER_EN(osc_en),
      .IO_HOLD(io_hold), .TIMER0_INC(t0_inc));
   wdt_osc_model i_osc (.WDT_OSC(wdt_osc));
   // 10 MHz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // event tallies and hang guard, sized well above the longest watchdog sweep
   always @(posedge sys_clk)
   begin
      n_wdr += int'(wdt_rst === 1'b1);
      n_inc += int'(t0_inc === 1'b1);
      n_mst += int'(mst_rst === 1'b1);
      n_psh += int'(push_pc === 1'b1);
      cyc++;
      if (cyc >= 40000)
      begin
         n_fail++;
         end_sim();
      end
   end
   // watchdog oscillator edges since the last clear
   always @(posedge wdt_osc)
      osc_cnt++;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; an idle cycle follows so psel is never reassigned in one step
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no wait-state count assumed; only the hang guard ends a stuck wait
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(what, rd, exp);
   endtask
   // one-cycle core pulse: 0 clear, 1 sleep, 2 irq entry, 3 timer tick, 4 timer write
   task automatic pulse(input int which);
      case (which)
         0: clr_i <= 1'b1;
         1: sleep_i <= 1'b1;
         2: irq_i <= 1'b1;
         4: t0_write <= 1'b1;
         default: t0_tick <= 1'b1;
      endcase
      @(posedge sys_clk);
      {clr_i, sleep_i, irq_i, t0_tick, t0_write} <= 5'h00;
      @(posedge sys_clk);
   endtask
   task automatic wait_evt(input int lim);
      n = 0;
      while (resume !== 1'b1 && wdt_rst !== 1'b1 && n < lim)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   task automatic do_reset(input logic f);
      fuse <= f;
      reset <= 1'b1;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      {psel, penable, pwrite, clr_i, sleep_i, irq_i, t0_tick, irq_pending, global_irq_enable} = '0;
      {t0_write, paddr, pwdata, wake_req} = '0;
      {master_clear_pin_n, fuse, reset} = 3'b111;
      do_reset(1'b1);
      // defaults and refused accesses
      pulse(2);
      rchk("option", OPT, 32'hff);
      rchk("status", ST, 32'h18);
      rchk("wake_en", WEN, 32'h0);
      apb(12'h100, 1'b1, 32'h0);
      chk("unmapped err", err, 1);
      apb(ST, 1'b1, 32'h0);
      chk("status write err", err, 1);
      chk("stack push", n_psh, 1);
      // prescaler lent to timer0: one increment per two ticks
      apb(OPT, 1'b1, 32'h00);
      pulse(0);
      m = n_inc;
      repeat (8) pulse(3);
      @(posedge sys_clk);
      chk("timer0 incs", n_inc - m, 4);
      // a timer0 write empties the prescaler, so each single tick starts from zero
      m = n_inc;
      repeat (2)
      begin
         pulse(4);
         pulse(3);
      end
      @(posedge sys_clk);
      chk("timer0 clear", n_inc - m, 0);
      // every watchdog ratio, counted in oscillator edges
      for (int ps = 0; ps < 8; ps++)
      begin
         apb(OPT, 1'b1, 32'hf8 | ps);
         // second clear outlasts any expiry that met the first
         repeat (2) pulse(0);
         osc_cnt = 0;
         wait_evt(20000);
         chk("wdt reset", {resume, wdt_rst}, 2'b01);
         chk("wdt period", $unsigned(osc_cnt - (BASE << ps) + 1) <= 2, 1);
         rchk("wdt status", ST, 32'h08);
      end
      // regular clears hold the watchdog off
      pulse(0);
      apb(OPT, 1'b1, 32'h08);
      m = n_wdr;
      repeat (12)
      begin
         pulse(0);
         repeat (18) @(posedge sys_clk);
      end
      chk("no wdt reset", n_wdr - m, 0);
      rchk("assign kept", OPT, 32'h08);
      // each wake source alone, others unenabled or clock-bound
      apb(OPT, 1'b1, 32'hff);
      for (int s = 0; s < 5; s++)
      begin
         apb(WEN, 1'b1, 32'h20 | (32'h1 << s));
         global_irq_enable <= s[0];
         wake_req <= 6'h3f ^ (6'h1 << s);
         pulse(1);
         repeat (8) @(posedge sys_clk);
         chk("asleep", {osc_en, io_hold}, 2'b01);
         rchk("sleep status", ST, 32'h11);
         wake_req <= 6'h3f;
         wait_evt(20);
         chk("wake kind", {wdt_rst, resume, vector}, {2'b01, s[0]});
         wake_req <= 6'h00;
         rchk("woke status", ST, 32'h10);
      end
      // pending interrupt: skipped sleep, then instant wake
      pulse(0);
      irq_pending <= 1'b1;
      global_irq_enable <= 1'b0;
      pulse(1);
      repeat (4) @(posedge sys_clk);
      chk("nop sleep", osc_en, 1);
      rchk("nop status", ST, 32'h18);
      global_irq_enable <= 1'b1;
      pulse(1);
      wait_evt(20);
      chk("instant wake", {wdt_rst, resume}, 2'b01);
      irq_pending <= 1'b0;
      rchk("instant status", ST, 32'h10);
      // watchdog wake from sleep
      apb(OPT, 1'b1, 32'h08);
      pulse(1);
      wait_evt(300);
      chk("wdt wake", {wdt_rst, resume, vector}, 3'b010);
      rchk("wdt wake status", ST, 32'h00);
      // master clear while asleep
      apb(OPT, 1'b1, 32'hff);
      pulse(1);
      m = n_mst;
      master_clear_pin_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      master_clear_pin_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk("master_clear_pin pulses", n_mst - m, 1);
      rchk("master_clear_pin status", ST, 32'h10);
      // fuse cleared: the watchdog never fires
      do_reset(1'b0);
      apb(OPT, 1'b1, 32'h08);
      m = n_wdr;
      repeat (300) @(posedge sys_clk);
      chk("fuse off", n_wdr - m, 0);
      end_sim();
   end
endmodule // wdt_sleep_ctrl_tb
